// >>> rtl/ifd_pkg.sv
// Summary of operation
// - generic format: two-byte op-code, source and destination fields of 0 to 3 bytes
// - quick format: two-byte op-code with small signed immediate, destination of 0 to 2 bytes
// - short format: one-byte op-code, restricted modes, source and destination 0 to 2 bytes
// - zero format: one-byte op-code, immediate always zero, destination of 0 to 2 bytes
// - each instruction gets one format; length is op-code plus operand field lengths
// - jumps use short, byte, word or absolute distance, each with its own width
// - short jump reaches start plus 2 to 9; byte jump reaches -128 to +127
package ifd_pkg;

  localparam logic [2:0] IFD_CLS_GEN0   = 3'h0;
  localparam logic [2:0] IFD_CLS_GEN1   = 3'h1;
  localparam logic [2:0] IFD_CLS_QUICK0 = 3'h2;
  localparam logic [2:0] IFD_CLS_QUICK1 = 3'h3;
  localparam logic [2:0] IFD_CLS_SHORT  = 3'h4;
  localparam logic [2:0] IFD_CLS_ZERO   = 3'h5;
  localparam logic [2:0] IFD_CLS_JUMP   = 3'h6;

  localparam int unsigned IFD_CLS_MSB   = 7;
  localparam int unsigned IFD_CLS_LSB   = 5;
  localparam int unsigned IFD_IMM_SEL   = 4;

  localparam logic [3:0] IFD_OPC_LONG   = 4'h2;
  localparam logic [3:0] IFD_OPC_SHORT  = 4'h1;
  localparam logic [1:0] IFD_GEN_MAX    = 2'h3;
  localparam logic [1:0] IFD_LIM_MAX    = 2'h2;
  localparam logic [4:0] IFD_IMM_ONE    = 5'h01;
  localparam logic [19:0] IFD_JMP_S_BASE = 20'h00002;
  localparam logic [3:0] IFD_LEN_MAX    = 4'h8;

  typedef enum logic [1:0] {
    IFD_FMT_GEN   = 2'b00,
    IFD_FMT_QUICK = 2'b01,
    IFD_FMT_SHORT = 2'b10,
    IFD_FMT_ZERO  = 2'b11
  } ifd_fmt_e;

  typedef enum logic [1:0] {
    IFD_JMP_S = 2'b00,
    IFD_JMP_B = 2'b01,
    IFD_JMP_W = 2'b10,
    IFD_JMP_A = 2'b11
  } ifd_jmp_e;

  // generic mode nibble: top two bits give the field length 0..3
  function automatic logic [1:0] ifd_gen_len(input logic [3:0] mode);
    ifd_gen_len = mode[3:2];
  endfunction : ifd_gen_len

  // restricted mode code: register, dsp8, abs16, dsp8
  function automatic logic [1:0] ifd_lim_len(input logic [1:0] code);
    case (code)
      2'h0:    ifd_lim_len = 2'h0;
      2'h2:    ifd_lim_len = IFD_LIM_MAX;
      default: ifd_lim_len = 2'h1;
    endcase
  endfunction : ifd_lim_len

  function automatic logic [19:0] ifd_rel(input logic [19:0] pc, input logic [19:0] off);
    ifd_rel = pc + off;
  endfunction : ifd_rel

endpackage : ifd_pkg

`timescale 1ns/100ps
`default_nettype none

module ifd_opc_class
(
  input  wire logic [7:0]      i_b0,
  input  wire logic [7:0]      i_b1,
  output logic                 o_two_byte,
  output ifd_pkg::ifd_fmt_e    o_fmt,
  output logic                 o_jump,
  output ifd_pkg::ifd_jmp_e    o_jkind,
  output logic [1:0]           o_src_len,
  output logic [1:0]           o_dst_len,
  output logic [1:0]           o_disp_len,
  output logic [4:0]           o_imm,
  output logic                 o_illegal,
  output logic [3:0]           o_len
);

  logic [2:0] cls;
  logic [3:0] opc;
  logic [3:0] code;

  assign cls  = i_b0[ifd_pkg::IFD_CLS_MSB:ifd_pkg::IFD_CLS_LSB];
  assign code = i_b1[7:4];

  always_comb
  begin
    o_two_byte = 1'b0;
    o_fmt      = ifd_pkg::IFD_FMT_ZERO;
    o_jump     = 1'b0;
    o_jkind    = ifd_pkg::ifd_jmp_e'(i_b0[4:3]);
    o_src_len  = 2'h0;
    o_dst_len  = 2'h0;
    o_disp_len = 2'h0;
    o_imm      = 5'h00;
    o_illegal  = 1'b0;
    opc        = ifd_pkg::IFD_OPC_SHORT;
    case (cls)
      ifd_pkg::IFD_CLS_GEN0, ifd_pkg::IFD_CLS_GEN1:
      begin
        o_two_byte = 1'b1;
        o_fmt      = ifd_pkg::IFD_FMT_GEN;
        o_src_len  = ifd_pkg::ifd_gen_len(i_b1[7:4]);
        o_dst_len  = ifd_pkg::ifd_gen_len(i_b1[3:0]);
        opc        = ifd_pkg::IFD_OPC_LONG;
      end
      ifd_pkg::IFD_CLS_QUICK0, ifd_pkg::IFD_CLS_QUICK1:
      begin
        o_two_byte = 1'b1;
        o_fmt      = ifd_pkg::IFD_FMT_QUICK;
        o_dst_len  = ifd_pkg::ifd_lim_len(i_b1[1:0]);
        // selector bit shifts the range from -8..+7 up to -7..+8
        o_imm      = i_b0[ifd_pkg::IFD_IMM_SEL] ? {code[3], code} + ifd_pkg::IFD_IMM_ONE
                                                : {code[3], code};
        opc        = ifd_pkg::IFD_OPC_LONG;
      end
      ifd_pkg::IFD_CLS_SHORT:
      begin
        o_fmt     = ifd_pkg::IFD_FMT_SHORT;
        o_src_len = ifd_pkg::ifd_lim_len(i_b0[4:3]);
        o_dst_len = ifd_pkg::ifd_lim_len(i_b0[1:0]);
      end
      ifd_pkg::IFD_CLS_ZERO:
      begin
        o_fmt     = ifd_pkg::IFD_FMT_ZERO;
        o_dst_len = ifd_pkg::ifd_lim_len(i_b0[1:0]);
      end
      ifd_pkg::IFD_CLS_JUMP:
      begin
        o_fmt      = ifd_pkg::IFD_FMT_SHORT;
        o_jump     = 1'b1;
        o_disp_len = i_b0[4:3];
      end
      default:
      begin
        o_illegal = 1'b1;
      end
    endcase
    o_len = opc + {2'b00, o_src_len} + {2'b00, o_dst_len} + {2'b00, o_disp_len};
  end

endmodule : ifd_opc_class

`default_nettype wire

// >>> rtl/ifd_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module ifd_decoder
(
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_ce,
  input  wire logic            i_byte_vld,
  input  wire logic [7:0]      i_byte,
  input  wire logic [19:0]     i_pc,
  output logic                 o_len_vld,
  output logic                 o_valid,
  output ifd_pkg::ifd_fmt_e    o_fmt,
  output logic [3:0]           o_len,
  output logic [1:0]           o_src_len,
  output logic [1:0]           o_dst_len,
  output logic [1:0]           o_disp_len,
  output logic [4:0]           o_imm,
  output logic                 o_jump,
  output ifd_pkg::ifd_jmp_e    o_jkind,
  output logic [19:0]          o_target,
  output logic                 o_illegal
);

  typedef enum logic [1:0] {
    IFD_ST_OP0  = 2'b00,
    IFD_ST_OP1  = 2'b01,
    IFD_ST_OPND = 2'b10
  } ifd_st_e;

  typedef struct packed {
    ifd_st_e           st;
    logic [7:0]        b0;
    logic [19:0]       pc;
    logic [2:0]        left;
    logic [1:0]        jidx;
    logic [23:0]       disp;
    logic              len_vld;
    logic              valid;
    ifd_pkg::ifd_fmt_e fmt;
    logic [3:0]        len;
    logic [1:0]        src_len;
    logic [1:0]        dst_len;
    logic [1:0]        disp_len;
    logic [4:0]        imm;
    logic              jump;
    ifd_pkg::ifd_jmp_e jkind;
    logic [19:0]       target;
    logic              illegal;
  } ifd_state_s;

  ifd_state_s s_q;
  ifd_state_s s_d;

  logic [7:0]        cls_b0;
  logic              c_two;
  ifd_pkg::ifd_fmt_e c_fmt;
  logic              c_jump;
  ifd_pkg::ifd_jmp_e c_jkind;
  logic [1:0]        c_src;
  logic [1:0]        c_dst;
  logic [1:0]        c_disp;
  logic [4:0]        c_imm;
  logic              c_ill;
  logic [3:0]        c_len;
  logic              take;
  logic              opc_done;
  logic [19:0]       pc_now;
  logic [23:0]       disp_full;

  // the incoming byte is byte 0 only while waiting for a new op-code
  assign cls_b0 = (s_q.st == IFD_ST_OP0) ? i_byte : s_q.b0;
  assign take   = i_ce & i_byte_vld;
  assign pc_now = (s_q.st == IFD_ST_OP0) ? i_pc : s_q.pc;

  ifd_opc_class u_class
  (
    .i_b0       (cls_b0),
    .i_b1       (i_byte),
    .o_two_byte (c_two),
    .o_fmt      (c_fmt),
    .o_jump     (c_jump),
    .o_jkind    (c_jkind),
    .o_src_len  (c_src),
    .o_dst_len  (c_dst),
    .o_disp_len (c_disp),
    .o_imm      (c_imm),
    .o_illegal  (c_ill),
    .o_len      (c_len)
  );

  // displacement arrives low byte first
  always_comb
  begin
    disp_full = s_q.disp;
    case (s_q.jidx)
      2'h0:    disp_full[7:0]   = i_byte;
      2'h1:    disp_full[15:8]  = i_byte;
      default: disp_full[23:16] = i_byte;
    endcase
  end

  always_comb
  begin
    s_d         = s_q;
    s_d.valid   = 1'b0;
    s_d.len_vld = 1'b0;
    opc_done    = 1'b0;
    if (take)
    begin
      case (s_q.st)
        IFD_ST_OP0:
        begin
          s_d.b0   = i_byte;
          s_d.pc   = i_pc;
          s_d.disp = 24'h000000;
          s_d.jidx = 2'h0;
          if (c_two)
          begin
            s_d.st = IFD_ST_OP1;
          end
          else
          begin
            opc_done = 1'b1;
          end
        end
        IFD_ST_OP1:
        begin
          opc_done = 1'b1;
        end
        IFD_ST_OPND:
        begin
          s_d.left = s_q.left - 3'h1;
          if (s_q.jump)
          begin
            s_d.disp = disp_full;
            s_d.jidx = s_q.jidx + 2'h1;
          end
          if (s_q.left == 3'h1)
          begin
            s_d.valid = 1'b1;
            s_d.st    = IFD_ST_OP0;
            // jkind holds raw op-code bits for non-jumps, so only jumps may touch the target
            if (s_q.jump)
            begin
              case (s_q.jkind)
                ifd_pkg::IFD_JMP_B:
                  s_d.target = ifd_pkg::ifd_rel(s_q.pc, {{12{disp_full[7]}}, disp_full[7:0]});
                ifd_pkg::IFD_JMP_W:
                  s_d.target = ifd_pkg::ifd_rel(s_q.pc, {{4{disp_full[15]}}, disp_full[15:0]});
                default:
                  s_d.target = disp_full[19:0];
              endcase
            end
          end
        end
        default:
        begin
          s_d.st = IFD_ST_OP0;
        end
      endcase
    end
    // length is published at op-code time so fetch can find the next boundary early
    if (opc_done)
    begin
      s_d.len_vld  = 1'b1;
      s_d.fmt      = c_fmt;
      s_d.len      = c_len;
      s_d.src_len  = c_src;
      s_d.dst_len  = c_dst;
      s_d.disp_len = c_disp;
      s_d.imm      = c_imm;
      s_d.jump     = c_jump;
      s_d.jkind    = c_jkind;
      s_d.illegal  = c_ill;
      s_d.target   = 20'h00000;
      s_d.left     = {1'b0, c_src} + {1'b0, c_dst} + {1'b0, c_disp};
      if (s_d.left == 3'h0)
      begin
        s_d.valid = 1'b1;
        s_d.st    = IFD_ST_OP0;
        // short jump carries its distance in the op-code: start + 2..9
        if (c_jump)
        begin
          s_d.target = ifd_pkg::ifd_rel(pc_now,
                         ifd_pkg::IFD_JMP_S_BASE + {17'h00000, cls_b0[2:0]});
        end
      end
      else
      begin
        s_d.st = IFD_ST_OPND;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_q <= '0;
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end

  assign o_len_vld  = s_q.len_vld;
  assign o_valid    = s_q.valid;
  assign o_fmt      = s_q.fmt;
  assign o_len      = s_q.len;
  assign o_src_len  = s_q.src_len;
  assign o_dst_len  = s_q.dst_len;
  assign o_disp_len = s_q.disp_len;
  assign o_imm      = s_q.imm;
  assign o_jump     = s_q.jump;
  assign o_jkind    = s_q.jkind;
  assign o_target   = s_q.target;
  assign o_illegal  = s_q.illegal;

  // helper: bytes actually taken for the instruction just finished
  logic [3:0]  chk_cnt_q;
  logic [3:0]  chk_last_q;
  logic [19:0] chk_off;

  assign chk_off = s_q.target - s_q.pc;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      chk_cnt_q  <= 4'h0;
      chk_last_q <= 4'h0;
    end
    else if (take)
    begin
      if (s_d.valid)
      begin
        chk_cnt_q  <= 4'h0;
        chk_last_q <= chk_cnt_q + 4'h1;
      end
      else
      begin
        chk_cnt_q <= chk_cnt_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_gen_len: assert property (o_valid && o_fmt == ifd_pkg::IFD_FMT_GEN |->
    o_len == 4'h2 + {2'b00, o_src_len} + {2'b00, o_dst_len})
    else $error("generic length is not two plus field lengths");

  chk_quick_imm: assert property (o_valid && o_fmt == ifd_pkg::IFD_FMT_QUICK |->
    $signed(o_imm) >= -5'sd8 && $signed(o_imm) <= 5'sd8 && o_dst_len <= 2'h2
    && o_len == 4'h2 + {2'b00, o_dst_len})
    else $error("quick immediate or length out of range");

  chk_short_len: assert property (o_valid && o_fmt == ifd_pkg::IFD_FMT_SHORT && !o_jump |->
    o_src_len <= 2'h2 && o_dst_len <= 2'h2
    && o_len == 4'h1 + {2'b00, o_src_len} + {2'b00, o_dst_len})
    else $error("short format length wrong");

  chk_zero_fmt: assert property (o_valid && o_fmt == ifd_pkg::IFD_FMT_ZERO && !o_illegal |->
    o_imm == 5'h00 && o_src_len == 2'h0 && o_len == 4'h1 + {2'b00, o_dst_len})
    else $error("zero format immediate or length wrong");

  chk_bytes_taken: assert property (o_valid |-> chk_last_q == o_len)
    else $error("bytes consumed differ from reported length");

  chk_jump_width: assert property (o_valid && o_jump |->
    o_disp_len == o_jkind && o_len == 4'h1 + {2'b00, o_disp_len})
    else $error("jump displacement width does not match distance kind");

  chk_short_reach: assert property (o_valid && o_jump && o_jkind == ifd_pkg::IFD_JMP_S |->
    chk_off >= 20'h00002 && chk_off <= 20'h00009)
    else $error("short jump target out of reach");

  chk_byte_reach: assert property (o_valid && o_jump && o_jkind == ifd_pkg::IFD_JMP_B |->
    $signed(chk_off) >= -20'sd128 && $signed(chk_off) <= 20'sd127)
    else $error("byte jump target out of reach");

  chk_early_len: assert property (o_len_vld && !o_valid && i_ce |=>
    !o_len_vld && $stable(o_len))
    else $error("reported length moved before instruction finished");

  cov_short_jump: cover property (o_valid && o_jump && o_jkind == ifd_pkg::IFD_JMP_S);
  cov_gen_max:    cover property (o_valid && o_len == ifd_pkg::IFD_LEN_MAX);
  cov_quick_top:  cover property (o_valid && o_fmt == ifd_pkg::IFD_FMT_QUICK && o_imm == 5'h08);
  cov_abs_jump:   cover property (o_valid && o_jump && o_jkind == ifd_pkg::IFD_JMP_A);

endmodule : ifd_decoder

`default_nettype wire

// >>> dv/ifd_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none

// stands in for fetch: offers queued bytes back to back, or with a gap after each take
module ifd_fetch_model
(
  input  wire logic       i_clk,
  input  wire logic       i_ce,
  input  wire logic       i_slow,
  output logic            o_byte_vld,
  output logic [7:0]      o_byte
);
  logic [7:0] q[$];
  logic       took;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  initial
  begin
    o_byte_vld = 1'b0;
    o_byte     = 8'hA5;
  end

  // a byte leaves only on an edge where the enable is high
  always @(posedge i_clk)
  begin
    took = i_ce && o_byte_vld;
    #1;
    if (took)
      void'(q.pop_front());
    o_byte_vld = (q.size() != 0) && !(i_slow && took);
    // idle line toggles so a stale byte can never pass for fresh data
    o_byte = o_byte_vld ? q[0] : ~o_byte;
  end
endmodule : ifd_fetch_model

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

`define chk_eq(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
  localparam logic [19:0] PC = 20'h10100;

  typedef struct packed {
    logic [63:0] b;
    logic [1:0]  fmt;
    logic [3:0]  len;
    logic [1:0]  sl;
    logic [1:0]  dl;
    logic [1:0]  xl;
    logic [4:0]  imm;
    logic        j;
    logic [1:0]  jk;
    logic [19:0] tg;
    logic        il;
  } ifd_row_s;

  logic              i_clk, i_rst, i_ce, slow, byte_vld;
  logic              o_len_vld, o_valid, o_jump, o_illegal;
  logic [7:0]        byt;
  logic [19:0]       i_pc, o_target;
  logic [3:0]        o_len;
  logic [1:0]        o_src_len, o_dst_len, o_disp_len;
  logic [4:0]        o_imm;
  ifd_pkg::ifd_fmt_e o_fmt;
  ifd_pkg::ifd_jmp_e o_jkind;
  int                bad_count;
  int                tests_run;

  ifd_row_s rows [15] = '{
    '{64'h44332211_4C00, 2'h0, 4'h6, 2'h1, 2'h3, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h06050403_0201FF20, 2'h0, 4'h8, 2'h3, 2'h3, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h0, 2'h0, 4'h2, 2'h0, 2'h0, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h2211_7240, 2'h1, 4'h4, 2'h0, 2'h2, 2'h0, 5'h07, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h8050, 2'h1, 4'h2, 2'h0, 2'h0, 2'h0, 5'h19, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'hAA_7370, 2'h1, 4'h3, 2'h0, 2'h1, 2'h0, 5'h08, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h332211_9A, 2'h2, 4'h4, 2'h1, 2'h2, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'h55_A1, 2'h3, 4'h2, 2'h0, 2'h1, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h0},
    '{64'hC3, 2'h2, 4'h1, 2'h0, 2'h0, 2'h0, 5'h00, 1'h1, 2'h0, 20'h10105, 1'h0},
    '{64'hC7, 2'h2, 4'h1, 2'h0, 2'h0, 2'h0, 5'h00, 1'h1, 2'h0, 20'h10109, 1'h0},
    '{64'h80C8, 2'h2, 4'h2, 2'h0, 2'h0, 2'h1, 5'h00, 1'h1, 2'h1, 20'h10080, 1'h0},
    '{64'h7FC8, 2'h2, 4'h2, 2'h0, 2'h0, 2'h1, 5'h00, 1'h1, 2'h1, 20'h1017F, 1'h0},
    '{64'h8000D0, 2'h2, 4'h3, 2'h0, 2'h0, 2'h2, 5'h00, 1'h1, 2'h2, 20'h08100, 1'h0},
    '{64'h051234D8, 2'h2, 4'h4, 2'h0, 2'h0, 2'h3, 5'h00, 1'h1, 2'h3, 20'h51234, 1'h0},
    '{64'hE0, 2'h3, 4'h1, 2'h0, 2'h0, 2'h0, 5'h00, 1'h0, 2'h0, 20'h0, 1'h1}
  };

  ifd_decoder u_dut
  (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_byte_vld (byte_vld),
    .i_byte     (byt),
    .i_pc       (i_pc),
    .o_len_vld  (o_len_vld),
    .o_valid    (o_valid),
    .o_fmt      (o_fmt),
    .o_len      (o_len),
    .o_src_len  (o_src_len),
    .o_dst_len  (o_dst_len),
    .o_disp_len (o_disp_len),
    .o_imm      (o_imm),
    .o_jump     (o_jump),
    .o_jkind    (o_jkind),
    .o_target   (o_target),
    .o_illegal  (o_illegal)
  );

  ifd_fetch_model u_fm
  (
    .i_clk      (i_clk),
    .i_ce       (i_ce),
    .i_slow     (slow),
    .o_byte_vld (byte_vld),
    .o_byte     (byt)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // pre: bytes of an earlier instruction queued ahead; frz: cycle where enable drops for 4
  task automatic run(input ifd_row_s r, input int pre, input int frz);
    int k, lv, vv, ol;
    k = 0;
    lv = -1;
    vv = -1;
    ol = r.b[7] ? 1 : 2;
    i_pc = PC;
    for (int n = 0; n < r.len; n++)
      u_fm.push(r.b[8*n +: 8]);
    for (int c = 0; c < 40 && vv < 0; c++)
    begin
      @(posedge i_clk);
      if (i_ce && byte_vld)
        k++;
      #1;
      if (o_len_vld && k > pre && lv < 0)
        lv = k - pre;
      if (o_valid && k > pre)
        vv = k - pre;
      i_ce = !(c >= frz && c < frz + 4);
    end
    i_ce = 1'b1;
    `chk_eq("len_vld_at", ol, lv)
    `chk_eq("valid_at", r.len, vv)
    `chk_eq("fmt", r.fmt, o_fmt)
    `chk_eq("len", r.len, o_len)
    if (!r.j) `chk_eq("src_len", r.sl, o_src_len)
    if (!r.j) `chk_eq("dst_len", r.dl, o_dst_len)
    `chk_eq("disp_len", r.xl, o_disp_len)
    `chk_eq("imm", r.imm, o_imm)
    `chk_eq("jump", r.j, o_jump)
    if (r.j) `chk_eq("jkind", r.jk, o_jkind)
    `chk_eq("target", r.tg, o_target)
    `chk_eq("illegal", r.il, o_illegal)
    if (vv < 0)
    begin
      bad_count++;
      print_verdict();
    end
  endtask : run

  initial
  begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    slow = 1'b0;
    i_pc = 20'h00000;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    `chk_eq("reset_outs", 30'h0, {o_len_vld, o_valid, o_fmt, o_len, o_jump, o_target, o_illegal})
    foreach (rows[n])
      run(rows[n], 0, 99);
    // jump then short op-code with no idle cycle between
    u_fm.push(8'hC3);
    run(rows[6], 1, 99);
    slow = 1'b1;
    run(rows[0], 0, 99);
    slow = 1'b0;
    run(rows[0], 0, 2);
    // reset lands while operand bytes are still owed
    u_fm.push(8'h00);
    u_fm.push(8'hFF);
    for (int c = 0; c < 10 && !o_len_vld; c++)
      @(posedge i_clk) #1;
    `chk_eq("len_vld_mid", 1'b1, o_len_vld)
    `chk_eq("len_early", 4'h8, o_len)
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    `chk_eq("reset_mid", 30'h0, {o_len_vld, o_valid, o_fmt, o_len, o_jump, o_target, o_illegal})
    run(rows[8], 0, 99);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
